//--- logic/bsc_pkg.sv
// Constants and types shared by the conditional control-flow evaluator.
// Assumes a 16-bit word-addressed program counter and an 8-bit status register.
`default_nettype none

package bsc_pkg;

	localparam int unsigned PC_W     = 16;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned OFFSET_W = 7;
	localparam int unsigned CYC_W    = 2;

	// Bit positions inside the status flags register.
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;

	// Program counter steps.
	localparam logic [PC_W-1:0] PC_STEP_ONE   = 16'h0001;
	localparam logic [PC_W-1:0] PC_STEP_SKIP1 = 16'h0002;
	localparam logic [PC_W-1:0] PC_STEP_SKIP2 = 16'h0003;

	// Cycle counts.
	localparam logic [CYC_W-1:0] CYC_ONE   = 2'h1;
	localparam logic [CYC_W-1:0] CYC_TWO   = 2'h2;
	localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;

	typedef enum logic [4:0] {
		no_op                      = 5'h00,
		compare_immediate_op       = 5'h01,
		skip_reg_bit_clear_op      = 5'h02,
		skip_reg_bit_set_op        = 5'h03,
		skip_io_bit_clear_op       = 5'h04,
		branch_flag_clear_op       = 5'h05,
		branch_flag_set_op         = 5'h06,
		branch_equal_op            = 5'h07,
		branch_not_equal_op        = 5'h08,
		branch_carry_set_op        = 5'h09,
		branch_same_higher_op      = 5'h0A,
		branch_minus_op            = 5'h0B,
		branch_plus_op             = 5'h0C,
		branch_ge_signed_op        = 5'h0D,
		branch_lt_signed_op        = 5'h0E,
		branch_half_carry_set_op   = 5'h0F,
		branch_half_carry_clear_op = 5'h10,
		branch_copy_bit_set_op     = 5'h11,
		branch_copy_bit_clear_op   = 5'h12,
		branch_overflow_set_op     = 5'h13
	} bsc_op_e;

	// Sequence: idle, middle wait, last wait; idle to last wait and last wait to idle flip both bits.
	typedef enum logic [1:0] {
		st_idle      = 2'h0,
		st_wait_mid  = 2'h1,
		st_wait_last = 2'h3
	} bsc_state_e;

endpackage

`default_nettype wire

//--- logic/bsc_compare_flags.sv
// Flag generator for the subtract-without-store compare.
// Assumes operands are stable in the cycle they are sampled.
`timescale 1ns/1ns
`default_nettype none

module bsc_compare_flags
	import bsc_pkg::*;
(
	input  wire logic [DATA_W-1:0] i_reg_value,
	input  wire logic [DATA_W-1:0] i_imm_value,
	input  wire logic [DATA_W-1:0] i_flags_in,
	output logic      [DATA_W-1:0] o_flags_out
);

	wire logic [DATA_W-1:0] diff;
	wire logic              half_borrow;
	wire logic              full_borrow;
	wire logic              overflow;
	wire logic              negative;

	assign diff        = i_reg_value - i_imm_value;
	assign half_borrow = (~i_reg_value[3] & i_imm_value[3]) | (i_imm_value[3] & diff[3]) | (diff[3] & ~i_reg_value[3]);
	assign full_borrow = (~i_reg_value[7] & i_imm_value[7]) | (i_imm_value[7] & diff[7]) | (diff[7] & ~i_reg_value[7]);
	assign overflow    = (i_reg_value[7] & ~i_imm_value[7] & ~diff[7]) | (~i_reg_value[7] & i_imm_value[7] & diff[7]);
	assign negative    = diff[7];

	always_comb begin
		o_flags_out         = i_flags_in;
		o_flags_out[FLAG_C] = full_borrow;
		o_flags_out[FLAG_Z] = (diff == 8'h00);
		o_flags_out[FLAG_N] = negative;
		o_flags_out[FLAG_V] = overflow;
		o_flags_out[FLAG_S] = negative ^ overflow;
		o_flags_out[FLAG_H] = half_borrow;
	end

endmodule

`default_nettype wire

//--- logic/bsc_branch_skip_unit.sv
// Conditional control-flow evaluator: compare, bit skips and relative branches.
// Assumes decoded operands from the same clock domain and fetch reporting the next word count.
//
// Overview of operation
// - Compare immediate subtracts constant, updates Z N V C H S, one cycle.
// - Register bit clear skip jumps past next instruction; one to three cycles.
// - Register bit set skip jumps past next instruction; one to three cycles.
// - I/O bit clear skip jumps past next instruction; one to three cycles.
// - Flag-clear branch picks status bit by index, branches when zero.
// - Not-equal branch goes to pc plus offset plus one when Z clear.
// - Carry-set branch goes relative when carry flag is one.
// - Same-or-higher branch goes relative when carry flag is zero.
// - Minus branch on N one, plus branch on N zero.
// - Signed greater-or-equal branch when N xor V is zero.
// - Signed less-than branch when N xor V is one.
// - Half-carry-set branch when H flag is one.
// - Half-carry-clear branch when H flag is zero.
// - Copy-bit-set branch when T flag is one.
// - Copy-bit-clear branch when T flag is zero.
// - Overflow-set branch when V is one; branches and skips keep flags.
`timescale 1ns/1ns
`default_nettype none

module bsc_branch_skip_unit
	import bsc_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_sys_rst,
	input  wire logic                i_instr_valid,
	input  wire bsc_op_e             i_op,
	input  wire logic [PC_W-1:0]     i_pc,
	input  wire logic [DATA_W-1:0]   i_reg_value,
	input  wire logic [DATA_W-1:0]   i_io_value,
	input  wire logic [DATA_W-1:0]   i_imm_value,
	input  wire logic [2:0]          i_bit_sel,
	input  wire logic [OFFSET_W-1:0] i_offset,
	input  wire logic [DATA_W-1:0]   i_status_flags,
	input  wire logic                i_next_two_word,
	output logic                     o_ready,
	output logic                     o_done,
	output logic [PC_W-1:0]          o_next_pc,
	output logic [CYC_W-1:0]         o_cycles,
	output logic                     o_taken,
	output logic                     o_flags_we,
	output logic [DATA_W-1:0]        o_flags_value
);

	////////////////////////////////////////////////////////////////////////////
	// Decode and condition selection.

	bsc_state_e              state_reg;
	bsc_state_e              state_next;
	logic                    ready_reg;
	logic                    done_reg;
	logic [PC_W-1:0]         next_pc_reg;
	logic [CYC_W-1:0]        cycles_reg;
	logic                    taken_reg;
	logic                    flags_we_reg;
	logic [DATA_W-1:0]       flags_value_reg;
	logic                    cond;

	wire logic               accept;
	wire logic               is_skip;
	wire logic               is_branch;
	wire logic               is_compare;
	wire logic               flag_c;
	wire logic               flag_z;
	wire logic               flag_n;
	wire logic               flag_v;
	wire logic               flag_h;
	wire logic               flag_t;
	wire logic               sel_flag;
	wire logic               reg_bit;
	wire logic               io_bit;
	wire logic [PC_W-1:0]    offset_ext;
	wire logic [PC_W-1:0]    branch_pc;
	wire logic [PC_W-1:0]    skip_pc;
	wire logic [PC_W-1:0]    seq_pc;
	wire logic [PC_W-1:0]    target_pc;
	wire logic [CYC_W-1:0]   cycles_calc;
	wire logic [DATA_W-1:0]  compare_flags;

	assign accept     = i_instr_valid & (state_reg == st_idle);
	assign is_compare = (i_op == compare_immediate_op);
	assign is_skip    = (i_op == skip_reg_bit_clear_op) | (i_op == skip_reg_bit_set_op)
	                  | (i_op == skip_io_bit_clear_op);
	assign is_branch  = (i_op >= branch_flag_clear_op) & (i_op <= branch_overflow_set_op);

	assign flag_c   = i_status_flags[FLAG_C];
	assign flag_z   = i_status_flags[FLAG_Z];
	assign flag_n   = i_status_flags[FLAG_N];
	assign flag_v   = i_status_flags[FLAG_V];
	assign flag_h   = i_status_flags[FLAG_H];
	assign flag_t   = i_status_flags[FLAG_T];
	assign sel_flag = i_status_flags[i_bit_sel];
	assign reg_bit  = i_reg_value[i_bit_sel];
	assign io_bit   = i_io_value[i_bit_sel];

	always_comb begin
		cond = 1'b0;
		case (i_op)
			skip_reg_bit_clear_op: cond = ~reg_bit;
			skip_reg_bit_set_op: cond = reg_bit;
			skip_io_bit_clear_op: cond = ~io_bit;
			branch_flag_clear_op: cond = ~sel_flag;
			branch_flag_set_op: cond = sel_flag;
			branch_equal_op: cond = flag_z;
			branch_not_equal_op: cond = ~flag_z;
			branch_carry_set_op: cond = flag_c;
			branch_same_higher_op: cond = ~flag_c;
			branch_minus_op: cond = flag_n;
			branch_plus_op: cond = ~flag_n;
			branch_ge_signed_op: cond = ~(flag_n ^ flag_v);
			branch_lt_signed_op: cond = flag_n ^ flag_v;
			branch_half_carry_set_op: cond = flag_h;
			branch_half_carry_clear_op: cond = ~flag_h;
			branch_copy_bit_set_op: cond = flag_t;
			branch_copy_bit_clear_op: cond = ~flag_t;
			branch_overflow_set_op: cond = flag_v;
			default: cond = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Target address and cycle count.

	assign offset_ext = {{(PC_W-OFFSET_W){i_offset[OFFSET_W-1]}}, i_offset};
	assign seq_pc     = i_pc + PC_STEP_ONE;
	// relative target is pc plus offset plus one.
	assign branch_pc  = i_pc + offset_ext + PC_STEP_ONE;
	// skip over one or two words.
	assign skip_pc    = i_next_two_word ? (i_pc + PC_STEP_SKIP2) : (i_pc + PC_STEP_SKIP1);
	assign target_pc  = (is_branch & cond) ? branch_pc : ((is_skip & cond) ? skip_pc : seq_pc);

	assign cycles_calc = ~cond | ~(is_branch | is_skip) ? CYC_ONE
	                   : (is_branch ? CYC_TWO : (i_next_two_word ? CYC_THREE : CYC_TWO));

	// subtract without store and derive flags.
	bsc_compare_flags u_compare_flags (
		.i_reg_value (i_reg_value),
		.i_imm_value (i_imm_value),
		.i_flags_in  (i_status_flags),
		.o_flags_out (compare_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer for multi-cycle completion.

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_idle: begin
				if (accept && cycles_calc == CYC_THREE) begin
					state_next = st_wait_mid;
				end else if (accept && cycles_calc == CYC_TWO) begin
					state_next = st_wait_last;
				end
			end
			st_wait_mid: state_next = st_wait_last;
			st_wait_last: state_next = st_idle;
			default: state_next = st_idle;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg       <= st_idle;
			ready_reg       <= 1'b0;
			done_reg        <= 1'b0;
			next_pc_reg     <= PC_RESET;
			cycles_reg      <= CYC_ONE;
			taken_reg       <= 1'b0;
			flags_we_reg    <= 1'b0;
			flags_value_reg <= FLAGS_RESET;
		end else begin
			state_reg    <= state_next;
			ready_reg    <= (state_next == st_idle);
			done_reg     <= (accept && cycles_calc == CYC_ONE) || (state_reg == st_wait_last);
			flags_we_reg <= 1'b0;
			if (accept) begin
				next_pc_reg    <= target_pc;
				cycles_reg     <= cycles_calc;
				taken_reg      <= cond & (is_branch | is_skip);
				flags_we_reg   <= is_compare;
				if (is_compare) begin
					flags_value_reg <= compare_flags;
				end else begin
					flags_value_reg <= i_status_flags;
				end
			end
		end
	end

	assign o_ready       = ready_reg;
	assign o_done        = done_reg;
	assign o_next_pc     = next_pc_reg;
	assign o_cycles      = cycles_reg;
	assign o_taken       = taken_reg;
	assign o_flags_we    = flags_we_reg;
	assign o_flags_value = flags_value_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic     was_compare_reg;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			was_compare_reg <= 1'b0;
		end else if (accept) begin
			was_compare_reg <= is_compare;
		end
	end

	a_compare_one_cycle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && is_compare |=> o_done && o_flags_we && o_cycles == CYC_ONE)
		else $error("Compare did not finish in one cycle.");

	a_compare_zero_carry: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && is_compare |=> o_flags_value[FLAG_Z] == ($past(i_reg_value) == $past(i_imm_value))
			&& o_flags_value[FLAG_C] == ($past(i_reg_value) < $past(i_imm_value)))
		else $error("Compare zero or carry flag wrong.");

	a_flags_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_flags_we |-> was_compare_reg)
		else $error("Flags written by a branch or skip.");

	a_branch_taken_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && is_branch && cond |=> !o_done ##1 o_done && o_taken)
		else $error("Taken branch not two cycles.");

	a_branch_not_taken: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && is_branch && !cond |=> o_done && !o_taken && o_next_pc == $past(i_pc) + PC_STEP_ONE)
		else $error("Untaken branch wrong.");

	a_branch_target: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_not_equal_op && !flag_z
			|=> o_next_pc == $past(i_pc) + {{9{$past(i_offset[6])}}, $past(i_offset)} + 16'h0001)
		else $error("Relative branch target wrong.");

	a_skip_long: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && is_skip && cond && i_next_two_word
			|=> o_next_pc == $past(i_pc) + 16'h0003 ##0 !o_done [*2] ##1 o_done)
		else $error("Two-word skip wrong.");

	a_skip_short: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == skip_reg_bit_clear_op && !reg_bit && !i_next_two_word
			|=> o_next_pc == $past(i_pc) + 16'h0002 ##1 o_done && o_cycles == CYC_TWO)
		else $error("One-word skip wrong.");

	a_signed_branch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_lt_signed_op |=> o_taken == $past(flag_n ^ flag_v))
		else $error("Signed less-than decision wrong.");

	a_busy_not_ready: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		state_reg != st_idle |-> !o_ready)
		else $error("Ready while busy.");

	a_flags_copied: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && !is_compare |=> !o_flags_we && o_flags_value == $past(i_status_flags))
		else $error("Flags changed by a branch or skip.");

	a_reg_set_skip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == skip_reg_bit_set_op |=> o_taken == $past(i_reg_value[i_bit_sel]))
		else $error("Register bit set skip decision wrong.");

	a_io_clear_skip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == skip_io_bit_clear_op |=> o_taken == !$past(i_io_value[i_bit_sel]))
		else $error("I/O bit clear skip decision wrong.");

	a_flag_clear_branch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_flag_clear_op |=> o_taken == !$past(i_status_flags[i_bit_sel]))
		else $error("Indexed flag clear branch decision wrong.");

	a_carry_set_branch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_carry_set_op |=> o_taken == $past(i_status_flags[FLAG_C]))
		else $error("Carry set branch decision wrong.");

	a_same_higher_branch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_same_higher_op |=> o_taken == !$past(i_status_flags[FLAG_C]))
		else $error("Same or higher branch decision wrong.");

	a_ge_signed_branch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		accept && i_op == branch_ge_signed_op
			|=> o_taken == !$past(i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V]))
		else $error("Signed greater or equal decision wrong.");

endmodule

`default_nettype wire

//--- verification/bsc_branch_skip_unit_bench.sv
// Self-checking bench for the conditional control-flow evaluator.
// Assumes the evaluator package and one 250 MHz clock with synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module bsc_branch_skip_unit_bench
	import bsc_pkg::*;
;

	typedef struct packed {
		logic [PC_W-1:0]   pc;
		logic [CYC_W-1:0]  cyc;
		logic              tk;
		logic              we;
		logic [DATA_W-1:0] fl;
		logic [31:0]       due;
	} bsc_exp_s;

	logic                i_clk           = 1'b0;
	logic                i_sys_rst       = 1'b1;
	logic                i_instr_valid   = 1'b0;
	bsc_op_e             i_op            = no_op;
	logic [PC_W-1:0]     i_pc            = 16'h0000;
	logic [DATA_W-1:0]   i_reg_value     = 8'h00;
	logic [DATA_W-1:0]   i_io_value      = 8'h00;
	logic [DATA_W-1:0]   i_imm_value     = 8'h00;
	logic [2:0]          i_bit_sel       = 3'h0;
	logic [OFFSET_W-1:0] i_offset        = 7'h00;
	logic [DATA_W-1:0]   i_status_flags  = 8'h00;
	logic                i_next_two_word = 1'b0;
	logic                o_ready;
	logic                o_done;
	logic [PC_W-1:0]     o_next_pc;
	logic [CYC_W-1:0]    o_cycles;
	logic                o_taken;
	logic                o_flags_we;
	logic [DATA_W-1:0]   o_flags_value;
	logic [31:0]         cnt         = 32'h0;
	int                  errors      = 0;
	int                  check_count = 0;
	bsc_exp_s            exp_q[$];
	bsc_exp_s            got;

	bsc_branch_skip_unit dut (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_instr_valid(i_instr_valid),
		.i_op(i_op),
		.i_pc(i_pc),
		.i_reg_value(i_reg_value),
		.i_io_value(i_io_value),
		.i_imm_value(i_imm_value),
		.i_bit_sel(i_bit_sel),
		.i_offset(i_offset),
		.i_status_flags(i_status_flags),
		.i_next_two_word(i_next_two_word),
		.o_ready(o_ready),
		.o_done(o_done),
		.o_next_pc(o_next_pc),
		.o_cycles(o_cycles),
		.o_taken(o_taken),
		.o_flags_we(o_flags_we),
		.o_flags_value(o_flags_value)
	);

	always #2 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cnt <= cnt + 32'h1;
	end

	////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
		check_count++;
		if (ex !== sn) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, sn);
		end
	endtask

	function automatic bsc_exp_s model(input bsc_op_e op, input logic [PC_W-1:0] pc,
		input logic [DATA_W-1:0] rv, iv, kv, f, input logic [2:0] b,
		input logic [OFFSET_W-1:0] k, input logic two);
		bsc_exp_s e;
		logic [DATA_W-1:0] r;
		logic sk;
		logic br;
		e = '0;
		e.pc = pc + 16'h0001;
		e.cyc = 2'h1;
		e.fl = f;
		r = rv - kv;
		sk = 1'b0;
		br = 1'b0;
		case (op)
			compare_immediate_op: begin
				e.we = 1'b1;
				e.fl[FLAG_C] = (rv < kv);
				e.fl[FLAG_Z] = (r == 8'h00);
				e.fl[FLAG_N] = r[7];
				e.fl[FLAG_V] = (rv[7] != kv[7]) && (r[7] != rv[7]);
				e.fl[FLAG_S] = e.fl[FLAG_N] ^ e.fl[FLAG_V];
				e.fl[FLAG_H] = (rv[3:0] < kv[3:0]);
			end
			skip_reg_bit_clear_op: sk = ~rv[b];
			skip_reg_bit_set_op: sk = rv[b];
			skip_io_bit_clear_op: sk = ~iv[b];
			branch_flag_clear_op: br = ~f[b];
			branch_flag_set_op: br = f[b];
			branch_equal_op: br = f[FLAG_Z];
			branch_not_equal_op: br = ~f[FLAG_Z];
			branch_carry_set_op: br = f[FLAG_C];
			branch_same_higher_op: br = ~f[FLAG_C];
			branch_minus_op: br = f[FLAG_N];
			branch_plus_op: br = ~f[FLAG_N];
			branch_ge_signed_op: br = ~(f[FLAG_N] ^ f[FLAG_V]);
			branch_lt_signed_op: br = f[FLAG_N] ^ f[FLAG_V];
			branch_half_carry_set_op: br = f[FLAG_H];
			branch_half_carry_clear_op: br = ~f[FLAG_H];
			branch_copy_bit_set_op: br = f[FLAG_T];
			branch_copy_bit_clear_op: br = ~f[FLAG_T];
			branch_overflow_set_op: br = f[FLAG_V];
			default: br = 1'b0;
		endcase
		if (sk) begin
			e.tk = 1'b1;
			e.pc = pc + (two ? 16'h0003 : 16'h0002);
			e.cyc = two ? 2'h3 : 2'h2;
		end
		if (br) begin
			e.tk = 1'b1;
			e.pc = pc + {{9{k[6]}}, k} + 16'h0001;
			e.cyc = 2'h2;
		end
		return e;
	endfunction

	////////////////////////////////////////////////////////////
	// Mode 1 wraps below zero with the most negative offset and an equal compare.
	// Mode 2 wraps above the top with the most positive offset.
	task automatic issue(input bsc_op_e op, input int dir);
		logic [PC_W-1:0] pc;
		logic [DATA_W-1:0] rv;
		logic [DATA_W-1:0] iv;
		logic [DATA_W-1:0] kv;
		logic [DATA_W-1:0] f;
		logic [2:0] b;
		logic [OFFSET_W-1:0] k;
		logic two;
		bsc_exp_s e;
		int n;
		pc = (dir == 1) ? 16'h0000 : (dir == 2) ? 16'hFFFF : 16'($urandom);
		k = (dir == 1) ? 7'h40 : (dir == 2) ? 7'h3F : 7'($urandom);
		rv = 8'($urandom);
		iv = 8'($urandom);
		kv = (dir == 1) ? rv : 8'($urandom);
		f = 8'($urandom);
		b = 3'($urandom);
		two = 1'($urandom);
		n = 0;
		@(posedge i_clk);
		@(negedge i_clk);
		while (o_ready !== 1'b1) begin
			n++;
			if (n > 8) begin
				errors++;
				$display("mismatch o_ready expected 1 seen %b", o_ready);
				end_sim();
			end
			@(negedge i_clk);
		end
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_op <= op;
		i_pc <= pc;
		i_reg_value <= rv;
		i_io_value <= iv;
		i_imm_value <= kv;
		i_bit_sel <= b;
		i_offset <= k;
		i_status_flags <= f;
		i_next_two_word <= two;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		e = model(op, pc, rv, iv, kv, f, b, k, two);
		e.due = cnt + 32'(e.cyc);
		exp_q.push_back(e);
	endtask

	always @(posedge i_clk) begin
		if (o_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("mismatch o_done expected 0 seen 1");
			end else begin
				got = exp_q.pop_front();
				chk("o_next_pc", got.pc, o_next_pc);
				chk("o_cycles", 16'(got.cyc), 16'(o_cycles));
				chk("o_taken", 16'(got.tk), 16'(o_taken));
				chk("o_flags_we", 16'(got.we), 16'(o_flags_we));
				chk("o_flags_value", 16'(got.fl), 16'(o_flags_value));
				chk("o_done time", got.due[15:0], cnt[15:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h1F168C37));
		repeat (6) @(posedge i_clk);
		chk("o_ready", 16'h0000, 16'(o_ready));
		chk("o_next_pc", 16'h0000, o_next_pc);
		i_sys_rst <= 1'b0;
		for (int r = 0; r < 40; r++) begin
			for (int o = 0; o <= 20; o++) begin
				issue(bsc_op_e'(o[4:0]), r % 3);
			end
		end
		for (int w = 0; w < 10 && exp_q.size() != 0; w++) begin
			@(posedge i_clk);
		end
		if (exp_q.size() != 0) begin
			errors++;
			$display("mismatch o_done expected %0d more seen 0", exp_q.size());
		end
		end_sim();
	end

endmodule

`default_nettype wire
